//--- rtl/input_remap_pkg.sv
// Constants for the peripheral input remap block
// Behaviour
// R1 - Timer 3 clock from upper timer23 field
// R2 - Timer 2 clock from lower timer23 field
// R3 - Timer 5 clock from upper timer45 field
// R4 - Timer 4 clock from lower timer45 field
// R5 - Capture 2 from upper capture12 field
// R6 - Capture 1 from lower capture12 field
// R7 - Capture 4 from upper capture34 field
// R8 - Capture 3 from lower capture34 field
// R9 - Capture 5 register: low field only
// R10 - Compare fault B from upper field
// R11 - Compare fault A from lower field
// R12 - Serial 1 clear-to-send from upper field
// R13 - Serial 1 receive from lower field
// R14 - Serial 2 clear-to-send from upper field
// R15 - Serial 2 receive from lower field
// R16 - SPI 1 clock from upper field
// R17 - SPI 1 data from lower field
// R18 - Unimplemented bits read as zero
// R19 - Fields reset to all ones, read/write
// R20 - Writes accepted only while lock clear
// R21 - All-ones selector ties input low
// R22 - Selector n picks remappable pin n
// R23 - Writes to unimplemented bits ignored
package input_remap_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Bus and field layout
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam int SEL_W = 5;
	localparam int HI_LSB = 8;
	localparam int LO_LSB = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Reset and pin numbering
	localparam logic [SEL_W-1:0] FIELD_RESET = 5'h1F;
	localparam logic [SEL_W-1:0] NULL_REMAP_PIN = 5'h1F;
	localparam int PIN_COUNT_DEFAULT = 31;
	localparam logic [DATA_W-1:0] READ_IDLE = 16'h0000;

	////////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [ADDR_W-1:0] TIMER23_CLOCK_INPUT_MAP = 5'h03;
	localparam logic [ADDR_W-1:0] TIMER45_CLOCK_INPUT_MAP = 5'h04;
	localparam logic [ADDR_W-1:0] CAPTURE12_INPUT_MAP = 5'h07;
	localparam logic [ADDR_W-1:0] CAPTURE34_INPUT_MAP = 5'h08;
	localparam logic [ADDR_W-1:0] CAPTURE5_INPUT_MAP = 5'h09;
	localparam logic [ADDR_W-1:0] COMPARE_FAULT_INPUT_MAP = 5'h0B;
	localparam logic [ADDR_W-1:0] SERIAL_PORT1_INPUT_MAP = 5'h12;
	localparam logic [ADDR_W-1:0] SERIAL_PORT2_INPUT_MAP = 5'h13;
	localparam logic [ADDR_W-1:0] SPI_PORT1_INPUT_MAP = 5'h14;

endpackage : input_remap_pkg

//--- rtl/remap_map_register.sv
// One input map register with an upper and a lower selector field
`timescale 1ns/100ps
module remap_map_register #(
	parameter logic HAS_HI = 1'b1
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_wr_en,
	input wire logic [input_remap_pkg::DATA_W-1:0] i_wr_data,
	output logic [input_remap_pkg::SEL_W-1:0] o_hi_sel,
	output logic [input_remap_pkg::SEL_W-1:0] o_lo_sel,
	output logic [input_remap_pkg::DATA_W-1:0] o_rd_word
);

	typedef struct packed {
		logic [input_remap_pkg::SEL_W-1:0] hi;
		logic [input_remap_pkg::SEL_W-1:0] lo;
	} map_state_s;

	map_state_s state_reg;
	map_state_s state_next;

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		state_next = state_reg;
		if (i_wr_en)
		begin
			// R23 only field bits stored
			state_next.lo = i_wr_data[input_remap_pkg::LO_LSB +: input_remap_pkg::SEL_W];
			// R9 upper field optional
			if (HAS_HI)
			begin
				state_next.hi = i_wr_data[input_remap_pkg::HI_LSB +: input_remap_pkg::SEL_W];
			end
		end
	end

	// R19 fields reset high
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_reg <= {input_remap_pkg::FIELD_RESET, input_remap_pkg::FIELD_RESET};
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read view
	always_comb
	begin
		// R18 unimplemented read zero
		o_rd_word = input_remap_pkg::READ_IDLE;
		o_rd_word[input_remap_pkg::LO_LSB +: input_remap_pkg::SEL_W] = state_reg.lo;
		if (HAS_HI)
		begin
			o_rd_word[input_remap_pkg::HI_LSB +: input_remap_pkg::SEL_W] = state_reg.hi;
		end
	end

	assign o_hi_sel = state_reg.hi;
	assign o_lo_sel = state_reg.lo;

endmodule : remap_map_register

//--- rtl/remap_pin_select.sv
// Picks one remappable pin level by selector number
`timescale 1ns/100ps
module remap_pin_select #(
	parameter int PIN_COUNT = input_remap_pkg::PIN_COUNT_DEFAULT
) (
	input wire logic [PIN_COUNT-1:0] i_remappable_pin,
	input wire logic [input_remap_pkg::SEL_W-1:0] i_sel,
	output logic o_level
);

	function automatic logic pick_pin(
		input logic [PIN_COUNT-1:0] pins,
		input logic [input_remap_pkg::SEL_W-1:0] sel
	);
		logic level;
		level = 1'b0;
		// R22 pin n chosen
		for (int k = 0; k < PIN_COUNT; k++)
		begin
			if (sel == k[input_remap_pkg::SEL_W-1:0])
			begin
				level = pins[k];
			end
		end
		// R21 null pin grounded
		if (sel == input_remap_pkg::NULL_REMAP_PIN)
		begin
			level = 1'b0;
		end
		return level;
	endfunction : pick_pin

	assign o_level = pick_pin(i_remappable_pin, i_sel);

endmodule : remap_pin_select

//--- rtl/peripheral_input_remap.sv
// Input-side remap registers and peripheral input routing
`timescale 1ns/100ps
module peripheral_input_remap #(
	parameter int PIN_COUNT = input_remap_pkg::PIN_COUNT_DEFAULT
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic [input_remap_pkg::ADDR_W-1:0] i_addr,
	input wire logic [input_remap_pkg::DATA_W-1:0] i_wr_data,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	output logic [input_remap_pkg::DATA_W-1:0] o_rd_data,
	input wire logic i_pin_map_write_lock,
	input wire logic [PIN_COUNT-1:0] i_remappable_pin,
	output logic o_timer2_external_clock,
	output logic o_timer3_external_clock,
	output logic o_timer4_external_clock,
	output logic o_timer5_external_clock,
	output logic o_capture1_input,
	output logic o_capture2_input,
	output logic o_capture3_input,
	output logic o_capture4_input,
	output logic o_capture5_input,
	output logic o_compare_fault_a_input,
	output logic o_compare_fault_b_input,
	output logic o_serial1_rx_input,
	output logic o_serial1_cts_input,
	output logic o_serial2_rx_input,
	output logic o_serial2_cts_input,
	output logic o_spi1_clock_input,
	output logic o_spi1_data_input
);

	localparam int ROUTE_N = 17;

	typedef logic [input_remap_pkg::SEL_W-1:0] sel_t;

	typedef struct packed {
		logic [input_remap_pkg::DATA_W-1:0] rd_data;
		logic [ROUTE_N-1:0] routed;
	} remap_state_s;

	remap_state_s state_reg;
	remap_state_s state_next;

	////////////////////////////////////////////////////////////////////////////////
	// Write decode
	function automatic logic write_hit(
		input logic wr_en,
		input logic lock,
		input logic [input_remap_pkg::ADDR_W-1:0] addr,
		input logic [input_remap_pkg::ADDR_W-1:0] offset
	);
		return wr_en && !lock && (addr == offset);
	endfunction : write_hit

	// Write enables per register
	logic wr_timer23;
	logic wr_timer45;
	logic wr_capture12;
	logic wr_capture34;
	logic wr_capture5;
	logic wr_fault;
	logic wr_serial1;
	logic wr_serial2;
	logic wr_spi1;

	// R20 lock blocks writes
	assign wr_timer23 = write_hit(i_wr_en, i_pin_map_write_lock, i_addr,
		input_remap_pkg::TIMER23_CLOCK_INPUT_MAP);
	assign wr_timer45 = write_hit(i_wr_en, i_pin_map_write_lock, i_addr,
		input_remap_pkg::TIMER45_CLOCK_INPUT_MAP);
	assign wr_capture12 = write_hit(i_wr_en, i_pin_map_write_lock, i_addr,
		input_remap_pkg::CAPTURE12_INPUT_MAP);
	assign wr_capture34 = write_hit(i_wr_en, i_pin_map_write_lock, i_addr,
		input_remap_pkg::CAPTURE34_INPUT_MAP);
	assign wr_capture5 = write_hit(i_wr_en, i_pin_map_write_lock, i_addr,
		input_remap_pkg::CAPTURE5_INPUT_MAP);
	assign wr_fault = write_hit(i_wr_en, i_pin_map_write_lock, i_addr,
		input_remap_pkg::COMPARE_FAULT_INPUT_MAP);
	assign wr_serial1 = write_hit(i_wr_en, i_pin_map_write_lock, i_addr,
		input_remap_pkg::SERIAL_PORT1_INPUT_MAP);
	assign wr_serial2 = write_hit(i_wr_en, i_pin_map_write_lock, i_addr,
		input_remap_pkg::SERIAL_PORT2_INPUT_MAP);
	assign wr_spi1 = write_hit(i_wr_en, i_pin_map_write_lock, i_addr,
		input_remap_pkg::SPI_PORT1_INPUT_MAP);

	////////////////////////////////////////////////////////////////////////////////
	// Map registers
	sel_t timer3_clock_pin_select;
	sel_t timer2_clock_pin_select;
	sel_t timer5_clock_pin_select;
	sel_t timer4_clock_pin_select;
	sel_t capture2_pin_select;
	sel_t capture1_pin_select;
	sel_t capture4_pin_select;
	sel_t capture3_pin_select;
	sel_t capture5_pin_select;
	sel_t compare_fault_b_pin_select;
	sel_t compare_fault_a_pin_select;
	sel_t serial1_cts_pin_select;
	sel_t serial1_rx_pin_select;
	sel_t serial2_cts_pin_select;
	sel_t serial2_rx_pin_select;
	sel_t spi1_clock_pin_select;
	sel_t spi1_data_in_pin_select;

	// Read words of each register
	logic [input_remap_pkg::DATA_W-1:0] rd_timer23;
	logic [input_remap_pkg::DATA_W-1:0] rd_timer45;
	logic [input_remap_pkg::DATA_W-1:0] rd_capture12;
	logic [input_remap_pkg::DATA_W-1:0] rd_capture34;
	logic [input_remap_pkg::DATA_W-1:0] rd_capture5;
	logic [input_remap_pkg::DATA_W-1:0] rd_fault;
	logic [input_remap_pkg::DATA_W-1:0] rd_serial1;
	logic [input_remap_pkg::DATA_W-1:0] rd_serial2;
	logic [input_remap_pkg::DATA_W-1:0] rd_spi1;

	remap_map_register #(.HAS_HI(1'b1)) u_timer23_clock_input_map (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_wr_en(wr_timer23),
		.i_wr_data(i_wr_data),
		.o_hi_sel(timer3_clock_pin_select),
		.o_lo_sel(timer2_clock_pin_select),
		.o_rd_word(rd_timer23)
	);

	remap_map_register #(.HAS_HI(1'b1)) u_timer45_clock_input_map (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_wr_en(wr_timer45),
		.i_wr_data(i_wr_data),
		.o_hi_sel(timer5_clock_pin_select),
		.o_lo_sel(timer4_clock_pin_select),
		.o_rd_word(rd_timer45)
	);

	remap_map_register #(.HAS_HI(1'b1)) u_capture12_input_map (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_wr_en(wr_capture12),
		.i_wr_data(i_wr_data),
		.o_hi_sel(capture2_pin_select),
		.o_lo_sel(capture1_pin_select),
		.o_rd_word(rd_capture12)
	);

	remap_map_register #(.HAS_HI(1'b1)) u_capture34_input_map (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_wr_en(wr_capture34),
		.i_wr_data(i_wr_data),
		.o_hi_sel(capture4_pin_select),
		.o_lo_sel(capture3_pin_select),
		.o_rd_word(rd_capture34)
	);

	// R9 low field only
	remap_map_register #(.HAS_HI(1'b0)) u_capture5_input_map (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_wr_en(wr_capture5),
		.i_wr_data(i_wr_data),
		.o_hi_sel(),
		.o_lo_sel(capture5_pin_select),
		.o_rd_word(rd_capture5)
	);

	remap_map_register #(.HAS_HI(1'b1)) u_compare_fault_input_map (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_wr_en(wr_fault),
		.i_wr_data(i_wr_data),
		.o_hi_sel(compare_fault_b_pin_select),
		.o_lo_sel(compare_fault_a_pin_select),
		.o_rd_word(rd_fault)
	);

	remap_map_register #(.HAS_HI(1'b1)) u_serial_port1_input_map (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_wr_en(wr_serial1),
		.i_wr_data(i_wr_data),
		.o_hi_sel(serial1_cts_pin_select),
		.o_lo_sel(serial1_rx_pin_select),
		.o_rd_word(rd_serial1)
	);

	remap_map_register #(.HAS_HI(1'b1)) u_serial_port2_input_map (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_wr_en(wr_serial2),
		.i_wr_data(i_wr_data),
		.o_hi_sel(serial2_cts_pin_select),
		.o_lo_sel(serial2_rx_pin_select),
		.o_rd_word(rd_serial2)
	);

	remap_map_register #(.HAS_HI(1'b1)) u_spi_port1_input_map (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_wr_en(wr_spi1),
		.i_wr_data(i_wr_data),
		.o_hi_sel(spi1_clock_pin_select),
		.o_lo_sel(spi1_data_in_pin_select),
		.o_rd_word(rd_spi1)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Selector table, one entry per routed input
	sel_t route_sel [ROUTE_N];
	logic [ROUTE_N-1:0] route_level;

	always_comb
	begin
		// R2 timer 2 clock
		route_sel[0] = timer2_clock_pin_select;
		// R1 timer 3 clock
		route_sel[1] = timer3_clock_pin_select;
		// R4 timer 4 clock
		route_sel[2] = timer4_clock_pin_select;
		// R3 timer 5 clock
		route_sel[3] = timer5_clock_pin_select;
		// R6 capture 1 input
		route_sel[4] = capture1_pin_select;
		// R5 capture 2 input
		route_sel[5] = capture2_pin_select;
		// R8 capture 3 input
		route_sel[6] = capture3_pin_select;
		// R7 capture 4 input
		route_sel[7] = capture4_pin_select;
		// R9 capture 5 input
		route_sel[8] = capture5_pin_select;
		// R11 fault A input
		route_sel[9] = compare_fault_a_pin_select;
		// R10 fault B input
		route_sel[10] = compare_fault_b_pin_select;
		// R13 serial 1 receive
		route_sel[11] = serial1_rx_pin_select;
		// R12 serial 1 clear-to-send
		route_sel[12] = serial1_cts_pin_select;
		// R15 serial 2 receive
		route_sel[13] = serial2_rx_pin_select;
		// R14 serial 2 clear-to-send
		route_sel[14] = serial2_cts_pin_select;
		// R16 SPI 1 clock
		route_sel[15] = spi1_clock_pin_select;
		// R17 SPI 1 data
		route_sel[16] = spi1_data_in_pin_select;
	end

	// R22 pin multiplexers
	for (genvar g = 0; g < ROUTE_N; g++)
	begin : g_route
		remap_pin_select #(.PIN_COUNT(PIN_COUNT)) u_pin_select (
			.i_remappable_pin(i_remappable_pin),
			.i_sel(route_sel[g]),
			.o_level(route_level[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read mux and next state
	logic [input_remap_pkg::DATA_W-1:0] read_word;

	always_comb
	begin
		// R18 unmapped reads zero
		case (i_addr)
			input_remap_pkg::TIMER23_CLOCK_INPUT_MAP: read_word = rd_timer23;
			input_remap_pkg::TIMER45_CLOCK_INPUT_MAP: read_word = rd_timer45;
			input_remap_pkg::CAPTURE12_INPUT_MAP: read_word = rd_capture12;
			input_remap_pkg::CAPTURE34_INPUT_MAP: read_word = rd_capture34;
			input_remap_pkg::CAPTURE5_INPUT_MAP: read_word = rd_capture5;
			input_remap_pkg::COMPARE_FAULT_INPUT_MAP: read_word = rd_fault;
			input_remap_pkg::SERIAL_PORT1_INPUT_MAP: read_word = rd_serial1;
			input_remap_pkg::SERIAL_PORT2_INPUT_MAP: read_word = rd_serial2;
			input_remap_pkg::SPI_PORT1_INPUT_MAP: read_word = rd_spi1;
			default: read_word = input_remap_pkg::READ_IDLE;
		endcase
	end

	always_comb
	begin
		state_next = state_reg;
		// Read data stands one cycle
		if (i_rd_en)
		begin
			state_next.rd_data = read_word;
		end
		else
		begin
			state_next.rd_data = input_remap_pkg::READ_IDLE;
		end
		// Routed levels one edge late
		state_next.routed = route_level;
	end

	// R21 outputs start grounded
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign o_rd_data = state_reg.rd_data;

	// Timer external clocks
	assign o_timer2_external_clock = state_reg.routed[0];
	assign o_timer3_external_clock = state_reg.routed[1];
	assign o_timer4_external_clock = state_reg.routed[2];
	assign o_timer5_external_clock = state_reg.routed[3];

	// Capture inputs
	assign o_capture1_input = state_reg.routed[4];
	assign o_capture2_input = state_reg.routed[5];
	assign o_capture3_input = state_reg.routed[6];
	assign o_capture4_input = state_reg.routed[7];
	assign o_capture5_input = state_reg.routed[8];

	// Compare fault inputs
	assign o_compare_fault_a_input = state_reg.routed[9];
	assign o_compare_fault_b_input = state_reg.routed[10];

	// Serial port inputs
	assign o_serial1_rx_input = state_reg.routed[11];
	assign o_serial1_cts_input = state_reg.routed[12];
	assign o_serial2_rx_input = state_reg.routed[13];
	assign o_serial2_cts_input = state_reg.routed[14];

	// SPI port inputs
	assign o_spi1_clock_input = state_reg.routed[15];
	assign o_spi1_data_input = state_reg.routed[16];

endmodule : peripheral_input_remap

//--- bench/input_remap_monitor.sv
// Assertion checker for the peripheral input remap block
`timescale 1ns/100ps
module input_remap_monitor #(
	parameter int PIN_COUNT = 31
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic [input_remap_pkg::ADDR_W-1:0] i_addr,
	input wire logic [input_remap_pkg::DATA_W-1:0] i_wr_data,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [input_remap_pkg::DATA_W-1:0] o_rd_data,
	input wire logic i_pin_map_write_lock,
	input wire logic [PIN_COUNT-1:0] i_remappable_pin,
	input wire logic o_timer2_external_clock,
	input wire logic o_capture5_input,
	input wire logic o_compare_fault_b_input,
	input wire logic o_serial1_rx_input,
	input wire logic o_spi1_data_input
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	logic wrote_reg;
	logic [4:0] outs;
	assign outs = {o_timer2_external_clock, o_capture5_input, o_compare_fault_b_input,
		o_serial1_rx_input, o_spi1_data_input};
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
		if (!i_rst_n)
			wrote_reg <= 1'b0;
		else
			wrote_reg <= wrote_reg | (i_wr_en & ~i_pin_map_write_lock);
	////////////////////////////////////////////////////////////////////////////////
	rd_idle_a: assert property (!i_rd_en |=> o_rd_data == 16'h0000)
		else $error("read data not idle");
	unused_bits_a: assert property (o_rd_data[15:13] == 3'h0 && o_rd_data[7:5] == 3'h0)
		else $error("unused read bits set");
	capture5_hi_a: assert property (i_rd_en && i_addr == input_remap_pkg::CAPTURE5_INPUT_MAP
		|=> o_rd_data[15:5] == 11'h000) else $error("capture5 upper bits set");
	reset_value_a: assert property (!wrote_reg && i_rd_en
		&& i_addr == input_remap_pkg::SERIAL_PORT1_INPUT_MAP |=> o_rd_data == 16'h1F1F)
		else $error("reset value wrong");
	write_back_a: assert property (i_wr_en && !i_pin_map_write_lock
		&& i_addr == input_remap_pkg::SERIAL_PORT1_INPUT_MAP ##1 i_rd_en
		&& i_addr == input_remap_pkg::SERIAL_PORT1_INPUT_MAP
		|=> o_rd_data == ($past(i_wr_data, 2) & 16'h1F1F)) else $error("write not stored");
	locked_write_a: assert property (i_rd_en && i_addr == input_remap_pkg::SERIAL_PORT1_INPUT_MAP
		##1 i_wr_en && i_pin_map_write_lock && i_addr == input_remap_pkg::SERIAL_PORT1_INPUT_MAP
		##1 i_rd_en && i_addr == input_remap_pkg::SERIAL_PORT1_INPUT_MAP
		|=> o_rd_data == $past(o_rd_data, 2)) else $error("locked write took effect");
	null_reset_a: assert property (!wrote_reg |-> outs == 5'h00)
		else $error("input routed before setup");
	quiet_pins_a: assert property (i_remappable_pin == '0 |=> outs == 5'h00)
		else $error("input high with all pins low");
endmodule : input_remap_monitor

bind peripheral_input_remap input_remap_monitor #(.PIN_COUNT(PIN_COUNT)) u_monitor (
	.i_clk_sys, .i_rst_n, .i_addr, .i_wr_data, .i_wr_en, .i_rd_en, .o_rd_data,
	.i_pin_map_write_lock, .i_remappable_pin, .o_timer2_external_clock, .o_capture5_input,
	.o_compare_fault_b_input, .o_serial1_rx_input, .o_spi1_data_input);

//--- bench/remap_pin_model.sv
// Far-side model driving remappable pin levels
`timescale 1ns/100ps
module remap_pin_model #(
	parameter int PIN_COUNT = 31
) (
	input wire logic i_clk_sys,
	input wire logic [PIN_COUNT-1:0] i_level,
	output logic [PIN_COUNT-1:0] o_remappable_pin
);
	always_ff @(posedge i_clk_sys)
		o_remappable_pin <= i_level;
endmodule : remap_pin_model

//--- bench/testbench.sv
// Self-checking bench for the peripheral input remap block
`timescale 1ns/100ps
module testbench;
	localparam int PIN_COUNT = 31;
	logic i_clk_sys = 1'b0;
	logic i_rst_n = 1'b0;
	logic [4:0] i_addr = 5'h00;
	logic [15:0] i_wr_data = 16'h0000;
	logic i_wr_en = 1'b0;
	logic i_rd_en = 1'b0;
	logic i_pin_map_write_lock = 1'b0;
	logic [PIN_COUNT-1:0] level = '0;
	logic [PIN_COUNT-1:0] pins;
	logic [15:0] o_rd_data;
	logic [16:0] outs;
	logic [15:0] exp_next = 16'h0000;
	logic [15:0] exp_d = 16'h0000;
	logic rd_pend = 1'b0;
	logic [4:0] sel [17];
	logic [4:0] regs [9] = '{input_remap_pkg::TIMER23_CLOCK_INPUT_MAP,
		input_remap_pkg::TIMER45_CLOCK_INPUT_MAP, input_remap_pkg::CAPTURE12_INPUT_MAP,
		input_remap_pkg::CAPTURE34_INPUT_MAP, input_remap_pkg::CAPTURE5_INPUT_MAP,
		input_remap_pkg::COMPARE_FAULT_INPUT_MAP, input_remap_pkg::SERIAL_PORT1_INPUT_MAP,
		input_remap_pkg::SERIAL_PORT2_INPUT_MAP, input_remap_pkg::SPI_PORT1_INPUT_MAP};
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;
	always #50 i_clk_sys = ~i_clk_sys;
	remap_pin_model #(.PIN_COUNT(PIN_COUNT)) u_pins (.i_clk_sys(i_clk_sys), .i_level(level),
		.o_remappable_pin(pins));
	peripheral_input_remap #(.PIN_COUNT(PIN_COUNT)) u_dut (.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en),
		.i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .i_pin_map_write_lock(i_pin_map_write_lock),
		.i_remappable_pin(pins), .o_timer2_external_clock(outs[0]),
		.o_timer3_external_clock(outs[1]), .o_timer4_external_clock(outs[2]),
		.o_timer5_external_clock(outs[3]), .o_capture1_input(outs[4]),
		.o_capture2_input(outs[5]), .o_capture3_input(outs[6]), .o_capture4_input(outs[7]),
		.o_capture5_input(outs[8]), .o_compare_fault_a_input(outs[9]),
		.o_compare_fault_b_input(outs[10]), .o_serial1_rx_input(outs[11]),
		.o_serial1_cts_input(outs[12]), .o_serial2_rx_input(outs[13]),
		.o_serial2_cts_input(outs[14]), .o_spi1_data_input(outs[15]),
		.o_spi1_clock_input(outs[16]));
	////////////////////////////////////////////////////////////////////////////////
	task stop_test;
		$display("Checks %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	task check(input string name, input logic [16:0] e, input logic [16:0] s);
		n_tests++;
		if (s !== e)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, e, s);
		end
	endtask : check
	task wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge i_clk_sys);
		i_wr_en <= 1'b1;
		i_rd_en <= 1'b0;
		i_addr <= a;
		i_wr_data <= d;
	endtask : wr
	task rd(input logic [4:0] a, input logic [15:0] e);
		@(posedge i_clk_sys);
		i_rd_en <= 1'b1;
		i_wr_en <= 1'b0;
		i_addr <= a;
		exp_next <= e;
	endtask : rd
	task idle;
		@(posedge i_clk_sys);
		i_wr_en <= 1'b0;
		i_rd_en <= 1'b0;
	endtask : idle
	task route(input logic [PIN_COUNT-1:0] p);
		logic [16:0] e;
		@(posedge i_clk_sys);
		level <= p;
		repeat (2) @(posedge i_clk_sys);
		#1;
		for (int i = 0; i < 17; i++)
			e[i] = (sel[i] < PIN_COUNT) ? p[sel[i]] : 1'b0;
		check("routed", e, outs);
	endtask : route
	always @(posedge i_clk_sys)
	begin
		rd_pend <= i_rd_en;
		exp_d <= exp_next;
		cycles++;
		if (cycles == 4000)
		begin
			failures++;
			stop_test;
		end
	end
	always @(negedge i_clk_sys)
		if (rd_pend === 1'b1)
			check("read data", 17'(exp_d), 17'(o_rd_data));
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [4:0] lo;
		logic [4:0] hi;
		int idx;
		for (int i = 0; i < 17; i++)
			sel[i] = 5'h1F;
		repeat (16) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		// Reset values and null routing
		for (int j = 0; j < 9; j++)
			rd(regs[j], (j == 4) ? 16'h001F : 16'h1F1F);
		rd(5'h1F, 16'h0000);
		idle;
		route('1);
		// Distinct selectors, unused bits written high
		for (int j = 0; j < 9; j++)
		begin
			lo = 5'(2 * j + 3);
			hi = 5'(2 * j + 4);
			idx = (j > 4) ? 2 * j - 1 : 2 * j;
			wr(regs[j], {3'h7, hi, 3'h7, lo});
			rd(regs[j], (j == 4) ? {11'h000, lo} : {3'h0, hi, 3'h0, lo});
			sel[idx] = lo;
			if (j != 4)
				sel[idx + 1] = hi;
		end
		idle;
		for (int k = 0; k < 23; k++)
			route(31'h1 << k);
		route(31'h2AAAAAAA);
		route('0);
		// Writes while locked
		@(posedge i_clk_sys);
		i_pin_map_write_lock <= 1'b1;
		rd(input_remap_pkg::SERIAL_PORT1_INPUT_MAP, 16'h100F);
		wr(input_remap_pkg::SERIAL_PORT1_INPUT_MAP, 16'h0505);
		rd(input_remap_pkg::SERIAL_PORT1_INPUT_MAP, 16'h100F);
		idle;
		route('1);
		@(posedge i_clk_sys);
		i_pin_map_write_lock <= 1'b0;
		// Null selector again and unmapped place
		wr(input_remap_pkg::SPI_PORT1_INPUT_MAP, 16'h1F1F);
		rd(input_remap_pkg::SPI_PORT1_INPUT_MAP, 16'h1F1F);
		sel[15] = 5'h1F;
		sel[16] = 5'h1F;
		wr(5'h00, 16'h1F1F);
		rd(5'h00, 16'h0000);
		idle;
		route('1);
		repeat (2) @(posedge i_clk_sys);
		stop_test;
	end
endmodule : testbench
